// ===== hdl/sipc_pkg.sv
package sipc_pkg;
	// Bus geometry
	localparam int AW = 6;
	localparam int DW = 32;
	localparam int SW = 16;
	// Byte offsets of the register map
	localparam logic [AW-1:0] OFF_STATUS = 6'h00;
	localparam logic [AW-1:0] OFF_EVENT_MASK_REGISTER = 6'h04;
	localparam logic [AW-1:0] OFF_CID0 = 6'h08;
	localparam logic [AW-1:0] OFF_CMD = 6'h0c;
	localparam logic [AW-1:0] OFF_SIDE_PIN_CONTROL = 6'h10;
	localparam logic [AW-1:0] OFF_CHIP_CONTROL = 6'h14;
	localparam logic [AW-1:0] OFF_REV = 6'h18;
	localparam logic [AW-1:0] OFF_MODE = 6'h1c;
	localparam logic [AW-1:0] OFF_HW0 = 6'h20;
	localparam int HW_N = 4;
	localparam int HW_STEP = 4;
	// Status bit positions
	localparam int ST_RDY = 0;
	localparam int ST_CIA = 1;
	localparam int ST_CD = 2;
	localparam int ST_CPT = 3;
	localparam int ST_CNG = 4;
	localparam int ST_DTV = 5;
	localparam int ST_ATV = 6;
	localparam int ST_BSY = 7;
	localparam int ST_SD = 8;
	localparam int ST_ABT = 9;
	// Transitions that count as events, and the unmaskable bit
	localparam logic [SW-1:0] EV_RISE = 16'h037f;
	localparam logic [SW-1:0] EV_FALL = 16'h01ec;
	localparam logic [SW-1:0] EV_NOMASK = 16'h0200;
	// Reset values
	localparam logic [SW-1:0] EVENT_MASK_REGISTER_RST = 16'h0000;
	localparam logic [SW-1:0] HW_RST = 16'h0000;
	localparam logic [8:0] SPC_RST = 9'h000;
	localparam logic [7:0] CMD_RST = 8'h00;
	// Register fields
	localparam int CMD_W = 8;
	localparam int CMD_FILE = 7;
	localparam int CHIP_CONTROL_PD = 0;
	localparam int HW0_MA_STRONG = 0;
	localparam int HW0_MA_AUX = 1;
	localparam int HW2_PIN_REL = 0;
	localparam int HW_PIN_IDX = 2;
	localparam int SPC_W = 9;
	localparam int SPC_V0 = 0;
	localparam int SPC_V1 = 1;
	localparam int SPC_MODE = 2;
	localparam int SPC_POS = 5;
	// Side pin mode codes
	localparam logic [2:0] SPM_GPO = 3'h0;
	localparam logic [2:0] SPM_SPK = 3'h1;
	localparam logic [2:0] SPM_VPA = 3'h2;
	localparam logic [2:0] SPM_WIN = 3'h3;
	typedef enum logic [1:0] {MODE_RESET, MODE_ACTIVE, MODE_PWRDN} sipc_mode_t;
endpackage : sipc_pkg

// ===== hdl/sipc_side_pins.sv
`timescale 1ns/10ps
module sipc_side_pins
	import sipc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control and sources
	input wire logic [SPC_W-1:0] ctrl,
	input wire logic [SW-1:0] status,
	input wire logic [1:0] spk_status,
	input wire logic [1:0] prompt_addr_hi,
	// Pins
	output logic side_pin0,
	output logic side_pin1
);
	logic [2:0] mode;
	logic [3:0] pos;
	logic [SW:0] ext;
	logic [4:0] pos1;
	logic next_p0;
	logic next_p1;

	assign mode = ctrl[SPC_MODE +: 3];
	assign pos = ctrl[SPC_POS +: 4];
	assign ext = {1'b0, status};
	assign pos1 = 5'(pos) + 5'h01;

	always_comb begin
		next_p0 = ctrl[SPC_V0];
		next_p1 = ctrl[SPC_V1];
		case (mode)
			SPM_SPK: begin
				next_p0 = spk_status[0];
				next_p1 = spk_status[1];
			end
			SPM_VPA: begin
				next_p0 = prompt_addr_hi[0];
				next_p1 = prompt_addr_hi[1];
			end
			SPM_WIN: begin
				next_p0 = ext[pos];
				next_p1 = ext[pos1];
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			side_pin0 <= 1'b0;
			side_pin1 <= 1'b0;
		end else begin
			side_pin0 <= next_p0;
			side_pin1 <= next_p1;
		end
	end

	a_win_pins: assert property (@(posedge clk) disable iff (rst)
		mode == SPM_WIN |=> side_pin0 == $past(ext[pos]) && side_pin1 == $past(ext[pos1]))
		else $error("Status window pins wrong");
	a_gpo_pins: assert property (@(posedge clk) disable iff (rst)
		mode > SPM_WIN |=> side_pin0 == $past(ctrl[SPC_V0]) && side_pin1 == $past(ctrl[SPC_V1]))
		else $error("Spare mode code not general output");
endmodule : sipc_side_pins

// ===== hdl/sipc_top.sv
`timescale 1ns/10ps
module sipc_top
	import sipc_pkg::*;
#(
	parameter logic [SW-1:0] REV_VALUE = 16'h0a01 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DW-1:0] avs_writedata,
	output logic [DW-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Detectors and engine events
	input wire logic carrier_det,
	input wire logic progress_det,
	input wire logic fax_det,
	input wire logic keypad_det,
	input wire logic alert_det,
	input wire logic speech_det,
	input wire logic cmd_done,
	input wire logic file_done,
	input wire logic cid_valid,
	input wire logic [7:0] cid_byte,
	input wire logic abort_req,
	// Side pin sources
	input wire logic [1:0] spk_status,
	input wire logic [1:0] prompt_addr_hi,
	// Host interrupt and commands
	output logic irq,
	output logic cmd_strobe,
	output logic [CMD_W-1:0] cmd_code,
	// Power and memory pin control
	output logic osc_run,
	output logic core_run,
	output logic ext_run,
	output logic mc_release,
	output logic ma_pull_low,
	output logic ma_oe,
	// Side pins
	output logic side_pin0,
	output logic side_pin1
);
	logic ack;
	logic take;
	logic done;
	logic rd_done;
	logic wr_ok;
	logic rw_hit;
	logic freeze;
	logic [SW-1:0] event_mask_register;
	logic [SPC_W-1:0] side_pin_control;
	logic [SW-1:0] hw [HW_N];
	logic [7:0] cid_q;
	logic rdy_f;
	logic cia_f;
	logic bsy_f;
	logic abt_f;
	logic [SW-1:0] live;
	logic [SW-1:0] status_q;
	logic [SW-1:0] ev;
	logic [DW-1:0] next_rdata;
	sipc_mode_t mode;
	sipc_mode_t next_mode;

	// Bus handshake: request taken on first edge, answered on the second
	assign take = (avs_read | avs_write) & ~ack;
	assign done = (avs_read | avs_write) & ack;
	assign avs_waitrequest = take;
	assign rd_done = done & avs_read;
	assign wr_ok = done & avs_write & (~abt_f | avs_address == OFF_REV);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= take;
		end
	end

	always_comb begin
		rw_hit = 1'b0;
		unique case (avs_address)
			OFF_EVENT_MASK_REGISTER, OFF_CMD, OFF_SIDE_PIN_CONTROL, OFF_CHIP_CONTROL: rw_hit = 1'b1;
			default: rw_hit = (avs_address >= OFF_HW0) &&
				(avs_address < OFF_HW0 + 6'(HW_N * HW_STEP));
		endcase
	end

	// Control registers; abort restores reset values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			event_mask_register <= EVENT_MASK_REGISTER_RST;
		end else if (abort_req) begin
			event_mask_register <= EVENT_MASK_REGISTER_RST;
		end else if (wr_ok && avs_address == OFF_EVENT_MASK_REGISTER) begin
			event_mask_register <= avs_writedata[SW-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			side_pin_control <= SPC_RST;
		end else if (abort_req) begin
			side_pin_control <= SPC_RST;
		end else if (wr_ok && avs_address == OFF_SIDE_PIN_CONTROL) begin
			side_pin_control <= avs_writedata[SPC_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_code <= CMD_RST;
			cmd_strobe <= 1'b0;
		end else begin
			cmd_strobe <= wr_ok && avs_address == OFF_CMD && !abort_req;
			if (abort_req) begin
				cmd_code <= CMD_RST;
			end else if (wr_ok && avs_address == OFF_CMD) begin
				cmd_code <= avs_writedata[CMD_W-1:0];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < HW_N; g++) begin : g_hw
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					hw[g] <= HW_RST;
				end else if (abort_req) begin
					hw[g] <= HW_RST;
				end else if (wr_ok && avs_address == OFF_HW0 + 6'(g * HW_STEP)) begin
					hw[g] <= avs_writedata[SW-1:0];
				end
			end
		end
	endgenerate

	// Operating mode
	always_comb begin
		next_mode = mode;
		if (wr_ok && rw_hit) begin
			if (avs_address == OFF_CHIP_CONTROL && avs_writedata[CHIP_CONTROL_PD]) begin
				next_mode = MODE_PWRDN;
			end else begin
				next_mode = MODE_ACTIVE;
			end
		end else if (rd_done && rw_hit && !abt_f) begin
			next_mode = MODE_ACTIVE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= MODE_RESET;
		end else if (abort_req) begin
			mode <= MODE_RESET;
		end else begin
			mode <= next_mode;
		end
	end

	assign osc_run = mode == MODE_ACTIVE;
	assign core_run = mode == MODE_ACTIVE && !abt_f;
	assign ext_run = mode != MODE_RESET;
	assign mc_release = mode == MODE_PWRDN && hw[HW_PIN_IDX][HW2_PIN_REL];
	assign ma_oe = hw[0][HW0_MA_STRONG];
	assign ma_pull_low = ~hw[0][HW0_MA_STRONG] & ~hw[0][HW0_MA_AUX];

	// Event-driven flags; a set always wins over a clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdy_f <= 1'b0;
		end else if (cmd_done) begin
			rdy_f <= 1'b1;
		end else if (wr_ok && avs_address == OFF_CMD) begin
			rdy_f <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bsy_f <= 1'b0;
		end else if (wr_ok && avs_address == OFF_CMD && avs_writedata[CMD_FILE]) begin
			bsy_f <= 1'b1;
		end else if (file_done) begin
			bsy_f <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cia_f <= 1'b0;
			cid_q <= 8'h00;
		end else begin
			if (cid_valid) begin
				cia_f <= 1'b1;
				cid_q <= cid_byte;
			end else if (rd_done && avs_address == OFF_CID0) begin
				cia_f <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			abt_f <= 1'b0;
		end else if (abort_req) begin
			abt_f <= 1'b1;
		end else if (done && avs_write && avs_address == OFF_REV) begin
			abt_f <= 1'b0;
		end
	end

	// Status word, frozen while a status read is being answered
	always_comb begin
		live = '0;
		live[ST_RDY] = rdy_f;
		live[ST_CIA] = cia_f;
		live[ST_CD] = carrier_det;
		live[ST_CPT] = progress_det;
		live[ST_CNG] = fax_det;
		live[ST_DTV] = keypad_det;
		live[ST_ATV] = alert_det;
		live[ST_BSY] = bsy_f;
		live[ST_SD] = speech_det;
		live[ST_ABT] = abt_f;
	end

	assign freeze = rd_done && avs_address == OFF_STATUS;
	assign ev = ((live & ~status_q & EV_RISE) | (~live & status_q & EV_FALL))
		& (event_mask_register | EV_NOMASK);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= '0;
		end else if (!freeze) begin
			status_q <= live;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (!freeze && |ev) begin
			irq <= 1'b1;
		end else if (freeze) begin
			irq <= 1'b0;
		end
	end

	// Read data, captured when the request is taken
	always_comb begin
		next_rdata = '0;
		unique case (avs_address)
			OFF_STATUS: next_rdata[SW-1:0] = live;
			OFF_EVENT_MASK_REGISTER: next_rdata[SW-1:0] = event_mask_register;
			OFF_CID0: next_rdata[7:0] = cid_q;
			OFF_CMD: next_rdata[CMD_W-1:0] = cmd_code;
			OFF_SIDE_PIN_CONTROL: next_rdata[SPC_W-1:0] = side_pin_control;
			OFF_CHIP_CONTROL: next_rdata[CHIP_CONTROL_PD] = mode == MODE_PWRDN;
			OFF_REV: next_rdata[SW-1:0] = REV_VALUE;
			OFF_MODE: next_rdata[1:0] = mode;
			default: begin
				for (int i = 0; i < HW_N; i++) begin
					if (avs_address == OFF_HW0 + 6'(i * HW_STEP)) begin
						next_rdata[SW-1:0] = hw[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (take && avs_read) begin
			avs_readdata <= next_rdata;
		end
	end

	sipc_side_pins u_side (
		.clk(clk),
		.rst(rst),
		.ctrl(side_pin_control),
		.status(status_q),
		.spk_status(spk_status),
		.prompt_addr_hi(prompt_addr_hi),
		.side_pin0(side_pin0),
		.side_pin1(side_pin1)
	);

	// Checks
	sequence s_abort;
		abort_req ##1 abt_f;
	endsequence
	sequence s_status_read;
		take && avs_read && avs_address == OFF_STATUS ##1 freeze;
	endsequence

	a_abort_irq: assert property (@(posedge clk) disable iff (rst)
		s_abort |-> ##[1:3] irq)
		else $error("Abort did not raise interrupt");
	a_abort_regs: assert property (@(posedge clk) disable iff (rst)
		abort_req |=> event_mask_register == EVENT_MASK_REGISTER_RST && side_pin_control == SPC_RST && mode == MODE_RESET)
		else $error("Abort left registers set");
	a_abort_block: assert property (@(posedge clk) disable iff (rst)
		abt_f && done && avs_write && avs_address != OFF_REV |=> $stable(event_mask_register) && !cmd_strobe)
		else $error("Command accepted during abort");
	a_rev_clear: assert property (@(posedge clk) disable iff (rst)
		done && avs_write && avs_address == OFF_REV && !abort_req |=> !abt_f)
		else $error("Revision write kept abort");
	a_read_clear: assert property (@(posedge clk) disable iff (rst)
		s_status_read |=> !irq ##0 $stable(status_q))
		else $error("Status read did not clear interrupt");
	a_freeze_hold: assert property (@(posedge clk) disable iff (rst)
		freeze && live != status_q && |(event_mask_register & EV_RISE & live & ~status_q) |=> ##1 irq)
		else $error("Deferred event lost");
	a_mask_gate: assert property (@(posedge clk) disable iff (rst)
		!irq ##1 irq |-> $past(|ev))
		else $error("Interrupt without unmasked event");
	a_cia_set: assert property (@(posedge clk) disable iff (rst)
		cid_valid |=> cia_f)
		else $error("Caller ID flag not set");
	a_pd_enter: assert property (@(posedge clk) disable iff (rst)
		wr_ok && avs_address == OFF_CHIP_CONTROL && avs_writedata[CHIP_CONTROL_PD] && !abort_req
		|=> mode == MODE_PWRDN && !osc_run)
		else $error("Power-down not entered");
	a_pd_wake: assert property (@(posedge clk) disable iff (rst)
		mode == MODE_PWRDN && wr_ok && avs_address == OFF_EVENT_MASK_REGISTER && !abort_req
		|=> mode == MODE_ACTIVE)
		else $error("Access did not wake device");
endmodule : sipc_top

// ===== testbench/sipc_host.sv
`timescale 1ns/10ps
module sipc_host
	import sipc_pkg::*;
(
	// Clock
	input wire logic clk,
	// Avalon-MM master side
	output logic [AW-1:0] address,
	output logic read,
	output logic write,
	output logic [DW-1:0] writedata,
	input wire logic [DW-1:0] readdata,
	input wire logic waitrequest
);
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
	end
	// One bus cycle, held until waitrequest is seen low
	task automatic access(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d,
		output logic [DW-1:0] q);
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		@(posedge clk iff waitrequest === 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : access
endmodule : sipc_host

// ===== testbench/test_status_interrupt_power_control.sv
`timescale 1ns/10ps
module test_status_interrupt_power_control
	import sipc_pkg::*;
;
	localparam logic [SW-1:0] REV = 16'h5c37; // Arbitrary value
	logic clk = 1'b0, rst = 1'b1;
	logic [AW-1:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [DW-1:0] avs_writedata, avs_readdata, q;
	logic carrier_det = 0, progress_det = 0, fax_det = 0, keypad_det = 0;
	logic alert_det = 0, speech_det = 0, cmd_done = 0, file_done = 0;
	logic cid_valid = 0, abort_req = 0;
	logic [7:0] cid_byte = 8'h00;
	logic [1:0] spk_status = 2'h2, prompt_addr_hi = 2'h1;
	logic irq, cmd_strobe, osc_run, core_run, ext_run, mc_release, ma_pull_low, ma_oe;
	logic side_pin0, side_pin1;
	logic [CMD_W-1:0] cmd_code;
	int errors = 0, samples_checked = 0, cycles = 0;
	logic [10:0] spc_tab [5] = '{11'h006, 11'h011, 11'h022, 11'h032, 11'h059};

	initial forever #5 clk = ~clk;

	sipc_host host (.clk(clk), .address(avs_address), .read(avs_read), .write(avs_write),
		.writedata(avs_writedata), .readdata(avs_readdata), .waitrequest(avs_waitrequest));

	sipc_top #(.REV_VALUE(REV)) uut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.carrier_det(carrier_det), .progress_det(progress_det), .fax_det(fax_det),
		.keypad_det(keypad_det), .alert_det(alert_det), .speech_det(speech_det),
		.cmd_done(cmd_done), .file_done(file_done), .cid_valid(cid_valid),
		.cid_byte(cid_byte), .abort_req(abort_req), .spk_status(spk_status),
		.prompt_addr_hi(prompt_addr_hi), .irq(irq), .cmd_strobe(cmd_strobe),
		.cmd_code(cmd_code), .osc_run(osc_run), .core_run(core_run), .ext_run(ext_run),
		.mc_release(mc_release), .ma_pull_low(ma_pull_low), .ma_oe(ma_oe),
		.side_pin0(side_pin0), .side_pin1(side_pin1));

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		host.access(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
		host.access(1'b0, a, '0, q);
		chk(q & m, e);
	endtask : rd

	// Drives one event or detector input, chosen by number
	task automatic drive(input int sel, input logic v);
		case (sel)
			0: carrier_det <= v;
			1: fax_det <= v;
			2: cid_valid <= v;
			3: file_done <= v;
			4: cmd_done <= v;
			5: abort_req <= v;
			6: keypad_det <= v;
			default: begin
			end
		endcase
	endtask : drive

	task automatic pulse(input int sel);
		@(posedge clk);
		drive(sel, 1'b1);
		@(posedge clk);
		drive(sel, 1'b0);
	endtask : pulse

	task automatic det(input int sel, input logic v);
		@(posedge clk);
		drive(sel, v);
		tick(3);
	endtask : det

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			give_verdict();
		end
	end

	initial begin
		tick(5);
		rst <= 1'b0;
		rd(OFF_MODE, '1, 0);
		chk({osc_run, ext_run, ma_oe, ma_pull_low, irq}, 5'b00010);
		rd(6'h30, '1, 0);
		rd(OFF_MODE, '1, 0);
		wr(OFF_HW0 + 6'h08, 32'h1);
		tick(1);
		chk({osc_run, core_run, ma_pull_low}, 3'b111);
		rd(OFF_HW0, '1, 0);
		rd(OFF_MODE, '1, 1);
		// Both edges of carrier, the rising edge only of fax tone
		wr(OFF_EVENT_MASK_REGISTER, 32'h4);
		det(0, 1'b1);
		chk(irq, 1);
		rd(OFF_STATUS, 32'h4, 32'h4);
		tick(1);
		chk(irq, 0);
		det(1, 1'b1);
		chk(irq, 0);
		rd(OFF_STATUS, 32'h10, 32'h10);
		wr(OFF_EVENT_MASK_REGISTER, 32'h14);
		det(1, 1'b0);
		chk(irq, 0);
		det(0, 1'b0);
		chk(irq, 1);
		rd(OFF_STATUS, 32'h14, 0);
		// Keypad tone rise
		wr(OFF_EVENT_MASK_REGISTER, 32'h20);
		det(6, 1'b1);
		chk(irq, 1);
		rd(OFF_STATUS, 32'h20, 32'h20);
		// Caller ID byte
		wr(OFF_EVENT_MASK_REGISTER, 32'h2);
		@(posedge clk);
		cid_byte <= 8'h5a;
		pulse(2);
		tick(3);
		chk(irq, 1);
		rd(OFF_CID0, '1, 32'h5a);
		rd(OFF_STATUS, 32'h2, 0);
		// File command, busy and ready
		wr(OFF_EVENT_MASK_REGISTER, 32'h81);
		wr(OFF_CMD, 32'h81);
		tick(1);
		chk({cmd_strobe, cmd_code}, 9'h181);
		tick(1);
		chk(cmd_strobe, 0);
		rd(OFF_STATUS, 32'h81, 32'h80);
		pulse(3);
		pulse(4);
		tick(3);
		chk(irq, 1);
		rd(OFF_STATUS, 32'h81, 32'h1);
		// Side pin modes, ready high in the window at position zero
		for (int i = 0; i < 5; i++) begin
			wr(OFF_SIDE_PIN_CONTROL, {23'h0, spc_tab[i][10:2]});
			tick(2);
			chk({side_pin0, side_pin1}, spc_tab[i][1:0]);
		end
		// Power down and wake
		wr(OFF_CHIP_CONTROL, 32'h1);
		tick(1);
		chk({osc_run, ext_run, mc_release}, 3'b011);
		rd(OFF_MODE, '1, 2);
		rd(OFF_EVENT_MASK_REGISTER, '1, 32'h81);
		rd(OFF_MODE, '1, 1);
		// Abort and its clearing
		pulse(5);
		tick(3);
		chk({irq, core_run}, 2'b10);
		rd(OFF_STATUS, 32'h200, 32'h200);
		rd(OFF_EVENT_MASK_REGISTER, '1, 0);
		rd(OFF_MODE, '1, 0);
		wr(OFF_EVENT_MASK_REGISTER, 32'hffff);
		rd(OFF_EVENT_MASK_REGISTER, '1, 0);
		wr(OFF_REV, 32'h1234);
		rd(OFF_STATUS, 32'h200, 0);
		rd(OFF_REV, '1, {16'h0, REV});
		wr(OFF_EVENT_MASK_REGISTER, 32'h4);
		rd(OFF_EVENT_MASK_REGISTER, '1, 32'h4);
		give_verdict();
	end
endmodule : test_status_interrupt_power_control
